//--- hw/sfbl_consts.vh
// Constants for the status flag and bank layout block.
// Included by the top design file; holds definitions only.
`ifndef SFBL_CONSTS_VH
`define SFBL_CONSTS_VH
// Wishbone register offsets (byte addresses)
`define SFBL_REG_STATUS 4'h0
`define SFBL_REG_ACCESS 4'h4
`define SFBL_REG_INT_STAT 4'h8
`define SFBL_REG_INT_MASK 4'hc
// Status register field positions
`define SFBL_BIT_CARRY 0
`define SFBL_BIT_NIBBLE 1
`define SFBL_BIT_ZERO 2
`define SFBL_BIT_PD 3
`define SFBL_BIT_TO 4
// Reset values
`define SFBL_STATUS_POR 5'h18
`define SFBL_INT_MASK_RST 4'h0
// Bank offset region boundaries
`define SFBL_CORE_LAST 7'h0b
`define SFBL_PCR_FIRST 7'h0c
`define SFBL_PCR_LAST 7'h1f
`define SFBL_GRAM_FIRST 7'h20
`define SFBL_GRAM_LAST 7'h6f
`define SFBL_CRAM_FIRST 7'h70
`define SFBL_GRAM_BYTES 80
`define SFBL_CRAM_BYTES 16
// Linear space base address
`define SFBL_LIN_BASE 12'h000
// Region codes
`define SFBL_RGN_CORE 2'h0
`define SFBL_RGN_PCR 2'h1
`define SFBL_RGN_GRAM 2'h2
`define SFBL_RGN_CRAM 2'h3
`endif

//--- hw/sfbl_ram.v
// Byte RAM holding general and common RAM bytes.
// Assumes one clock; read data are registered.
`timescale 1ns/10ps
module sfbl_ram #(
    parameter AW = 12,
    parameter DEPTH = 2576
)(
    input wire clk,
    input wire we,
    input wire [AW-1:0] waddr,
    input wire [7:0] wdata,
    input wire [AW-1:0] raddr,
    output reg [7:0] rdata
);
    reg [7:0] mem_ff [0:DEPTH-1];

    // Synchronous write and registered read
    always @(posedge clk)
    begin
        if (we)
            mem_ff[waddr] <= wdata;
        rdata <= mem_ff[raddr];
    end
endmodule // sfbl_ram

//--- hw/sfbl_top.v
// Processor status flags and banked data memory layout.
// Assumes the core drives ALU operands, logic results and instruction strobes each cycle,
// and software reaches the status and interrupt registers over Wishbone.
// Operation
// RL1 - Status bits 7 to 5 always read zero and writes to them are dropped.
// RL2 - Time-out flag sets on power-up, clear or sleep; expiry clears it.
// RL3 - Power-down flag sets at power-up or watchdog clear, clears on sleep.
// RL4 - Power-on or brown-out reset loads 11000; others load only cause flags.
// RL5 - Zero flag follows whether the operation result is zero.
// RL6 - Nibble carry flag is the carry out of bit 3 for add and subtract.
// RL7 - Carry flag is the carry out of bit 7 for add and subtract.
// RL8 - Subtract adds the two's complement, so a one means no borrow.
// RL9 - Offsets 0ch to 1fh of every bank are the peripheral control region.
// RL10 - Offsets 20h to 6fh of selected banks are eighty bytes of general RAM.
// RL11 - Offsets 70h to 7fh reach one shared sixteen byte RAM in every bank.
// RL12 - General RAM is also reachable through a linear non-banked space.
// RL13 - Flag ops drop status data writes; cause flags take no writes.
// RL14 - Data addresses are twelve bits: five bits of bank and seven of offset.
// RL15 - Reads of unimplemented data locations return zero.
//
// Design decisions made here: register access over Wishbone and the register offsets.
`timescale 1ns/10ps
`include "sfbl_consts.vh"
module sfbl_top #(
    parameter GRAM_BANKS = 32,
    parameter BANK_W = 5
)(
    input wire CLK,
    input wire RST_N,
    input wire POR_BOR_N,
    input wire OTHER_RST_TO,
    input wire OTHER_RST_PD,
    input wire ALU_VALID,
    input wire ALU_IS_SUB,
    input wire ALU_ARITH,
    input wire [7:0] ALU_A,
    input wire [7:0] ALU_B,
    input wire LOGIC_VALID,
    input wire [7:0] LOGIC_RESULT,
    input wire WDT_CLEAR,
    input wire SLEEP_EXEC,
    input wire WDT_EXPIRE,
    input wire DATA_WE,
    input wire DATA_RE,
    input wire DATA_LINEAR,
    input wire [11:0] DATA_ADDR,
    input wire [7:0] DATA_WDATA,
    output reg [7:0] DATA_RDATA,
    output reg [1:0] DATA_REGION,
    output reg PCR_SEL,
    output reg [7:0] ALU_RESULT,
    output reg [7:0] STATUS_OUT,
    input wire [31:0] WB_ADR_I,
    input wire [31:0] WB_DAT_I,
    output reg [31:0] WB_DAT_O,
    input wire WB_WE_I,
    input wire [3:0] WB_SEL_I,
    input wire WB_STB_I,
    input wire WB_CYC_I,
    output reg WB_ACK_O,
    output wire IRQ
);
    localparam RAM_DEPTH = GRAM_BANKS * `SFBL_GRAM_BYTES + `SFBL_CRAM_BYTES;
    localparam [11:0] CRAM_BASE = GRAM_BANKS * `SFBL_GRAM_BYTES;
    localparam [11:0] LIN_SIZE = GRAM_BANKS * `SFBL_GRAM_BYTES;
    localparam [11:0] GRAM_STRIDE = `SFBL_GRAM_BYTES;

    // ================================================================
    // Arithmetic
    reg [4:0] flags_ff;
    reg [8:0] sum;
    reg [4:0] low_sum;
    reg [7:0] opnd_b;
    reg [7:0] nxt_result;

    // Subtract adds the inverted operand plus one; the plus one enters the
    // nibble sum too, so both carries read one when no borrow occurs
    always @*
    begin
        opnd_b = ALU_IS_SUB ? ~ALU_B : ALU_B;  // see RL8
        sum = {1'b0, ALU_A} + {1'b0, opnd_b} +
            {8'h00, ALU_IS_SUB};  // see RL7 RL8
        low_sum = {1'b0, ALU_A[3:0]} + {1'b0, opnd_b[3:0]} +
            {4'h0, ALU_IS_SUB};  // see RL6 RL8
        nxt_result = sum[7:0];
    end

    // ================================================================
    // Bus decode
    wire wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    wire wb_wr = wb_req & WB_WE_I & WB_SEL_I[0];
    wire [3:0] wb_off = WB_ADR_I[3:0];
    wire wb_hit = (WB_ADR_I[31:4] == 28'h0000000) & (wb_off[1:0] == 2'h0);
    wire sw_status_wr = wb_wr & wb_hit & (wb_off == `SFBL_REG_STATUS);
    wire core_status_wr = DATA_WE & ~DATA_LINEAR &
        (DATA_ADDR[6:0] == 7'h03);
    wire flag_instr = ALU_VALID | LOGIC_VALID;
    reg [3:0] int_stat_ff;
    reg [3:0] int_mask_ff;
    reg [7:0] access_ff;

    // ================================================================
    // Status flags
    reg [4:0] nxt_flags;
    always @*
    begin
        nxt_flags = flags_ff;
        // Data writes reach only the arithmetic flags
        if (core_status_wr && !flag_instr)  // see RL13
            nxt_flags[2:0] = DATA_WDATA[2:0];  // see RL1
        else if (sw_status_wr && !flag_instr)  // see RL13
            nxt_flags[2:0] = WB_DAT_I[2:0];  // see RL1
        if (ALU_VALID)
        begin
            nxt_flags[`SFBL_BIT_ZERO] = (nxt_result == 8'h00);  // see RL5
            if (ALU_ARITH)
            begin
                nxt_flags[`SFBL_BIT_NIBBLE] = low_sum[4];  // see RL6
                nxt_flags[`SFBL_BIT_CARRY] = sum[8];  // see RL7
            end
        end
        else if (LOGIC_VALID)
            nxt_flags[`SFBL_BIT_ZERO] = (LOGIC_RESULT == 8'h00);  // see RL5
        if (WDT_EXPIRE)
            nxt_flags[`SFBL_BIT_TO] = 1'b0;  // see RL2
        else if (WDT_CLEAR || SLEEP_EXEC)
            nxt_flags[`SFBL_BIT_TO] = 1'b1;  // see RL2
        if (SLEEP_EXEC)
            nxt_flags[`SFBL_BIT_PD] = 1'b0;  // see RL3
        else if (WDT_CLEAR)
            nxt_flags[`SFBL_BIT_PD] = 1'b1;  // see RL3
    end

    // Reset cause selects flag values
    always @(posedge CLK)
    begin
        if (!POR_BOR_N)
            flags_ff <= `SFBL_STATUS_POR;  // see RL4
        else if (!RST_N)
        begin
            flags_ff[`SFBL_BIT_TO] <= OTHER_RST_TO;  // see RL4
            flags_ff[`SFBL_BIT_PD] <= OTHER_RST_PD;  // see RL4
        end
        else
            flags_ff <= nxt_flags;
    end

    // ================================================================
    // Bank layout decode
    wire [BANK_W-1:0] bank = DATA_ADDR[11:7];  // see RL14
    wire [6:0] offs = DATA_ADDR[6:0];  // see RL14
    reg [1:0] region;
    reg ram_hit;
    reg [11:0] ram_addr;
    reg [11:0] lin_off;
    always @*
    begin
        region = `SFBL_RGN_CORE;
        ram_hit = 1'b0;
        ram_addr = 12'h000;
        lin_off = DATA_ADDR - `SFBL_LIN_BASE;
        if (DATA_LINEAR)
        begin
            region = `SFBL_RGN_GRAM;
            if (lin_off < LIN_SIZE)  // see RL12
            begin
                ram_hit = 1'b1;
                ram_addr = lin_off;
            end
        end
        else if (offs <= `SFBL_CORE_LAST)
            region = `SFBL_RGN_CORE;
        else if (offs <= `SFBL_PCR_LAST)
            region = `SFBL_RGN_PCR;  // see RL9
        else if (offs <= `SFBL_GRAM_LAST)
        begin
            region = `SFBL_RGN_GRAM;  // see RL10
            if (bank < GRAM_BANKS)
            begin
                ram_hit = 1'b1;
                // Product kept at twelve bits; the last bank start fits
                ram_addr = {{(12-BANK_W){1'b0}}, bank} * GRAM_STRIDE +
                    {5'h00, offs - `SFBL_GRAM_FIRST};
            end
        end
        else
        begin
            region = `SFBL_RGN_CRAM;  // see RL11
            ram_hit = 1'b1;
            ram_addr = CRAM_BASE + {5'h00, offs - `SFBL_CRAM_FIRST};
        end
    end

    wire [7:0] ram_rd;
    sfbl_ram #(.AW(12), .DEPTH(RAM_DEPTH)) u_ram (
        .clk(CLK),
        .we(DATA_WE & ram_hit),
        .waddr(ram_addr),
        .wdata(DATA_WDATA),
        .raddr(ram_addr),
        .rdata(ram_rd)
    );

    // Read hit tracking, registered in step with the RAM read data
    reg rd_ram_ff;
    reg rd_stat_ff;
    always @(posedge CLK)
    begin
        if (!RST_N)
        begin
            rd_ram_ff <= 1'b0;
            rd_stat_ff <= 1'b0;
        end
        else
        begin
            rd_ram_ff <= DATA_RE & ram_hit;
            rd_stat_ff <= DATA_RE & ~DATA_LINEAR & (offs == 7'h03);
        end
    end

    // Unimplemented locations read zero
    always @*
    begin
        if (rd_ram_ff)
            DATA_RDATA = ram_rd;
        else if (rd_stat_ff)
            DATA_RDATA = {3'h0, flags_ff};  // see RL1
        else
            DATA_RDATA = 8'h00;  // see RL15
    end

    // Registered outputs
    always @(posedge CLK)
    begin
        if (!RST_N)
        begin
            DATA_REGION <= `SFBL_RGN_CORE;
            PCR_SEL <= 1'b0;
            ALU_RESULT <= 8'h00;
            STATUS_OUT <= 8'h00;
        end
        else
        begin
            DATA_REGION <= region;
            PCR_SEL <= (region == `SFBL_RGN_PCR);  // see RL9
            if (ALU_VALID)
                ALU_RESULT <= nxt_result;
            STATUS_OUT <= {3'h0, nxt_flags};  // see RL1
        end
    end

    // ================================================================
    // Interrupts: 0 time-out, 1 sleep, 2 watchdog clear, 3 carry set
    wire [3:0] ev = {ALU_VALID & ALU_ARITH & sum[8], WDT_CLEAR,
        SLEEP_EXEC, WDT_EXPIRE};
    wire stat_clr_wr = wb_wr & wb_hit & (wb_off == `SFBL_REG_INT_STAT);
    always @(posedge CLK)
    begin
        if (!RST_N)
        begin
            int_stat_ff <= 4'h0;
            int_mask_ff <= `SFBL_INT_MASK_RST;
            access_ff <= 8'h00;
        end
        else
        begin
            // Set wins over a write-one clear
            int_stat_ff <= (int_stat_ff &
                ~(stat_clr_wr ? WB_DAT_I[3:0] : 4'h0)) | ev;
            if (wb_wr && wb_hit && wb_off == `SFBL_REG_INT_MASK)
                int_mask_ff <= WB_DAT_I[3:0];
            // Region of the address accessed in this cycle
            if (DATA_RE || DATA_WE)
                access_ff <= {6'h00, region};
        end
    end
    assign IRQ = |(int_stat_ff & int_mask_ff);

    // ================================================================
    // Wishbone slave: ack one cycle after request, zero for unmapped
    always @(posedge CLK)
    begin
        if (!RST_N)
        begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h00000000;
        end
        else
        begin
            WB_ACK_O <= wb_req;
            WB_DAT_O <= 32'h00000000;
            if (wb_req && wb_hit)
            begin
                case (wb_off)
                    `SFBL_REG_STATUS: WB_DAT_O <= {27'h0, flags_ff};
                    `SFBL_REG_ACCESS: WB_DAT_O <= {24'h0, access_ff};
                    `SFBL_REG_INT_STAT: WB_DAT_O <= {28'h0, int_stat_ff};
                    `SFBL_REG_INT_MASK: WB_DAT_O <= {28'h0, int_mask_ff};
                    default: WB_DAT_O <= 32'h00000000;
                endcase
            end
        end
    end
endmodule // sfbl_top

//--- sim/sfbl_core_model.sv
// Core-side model: drives ALU, event and data strobes of the block.
// Assumes one clock; each request stands for one cycle, then sub, arith and lin stay set.
`timescale 1ns/10ps
module sfbl_core_model (
    input wire CLK,
    output logic [9:0] s,
    output logic [7:0] a,
    output logic [7:0] b,
    output logic [11:0] ad
);
    // Strobes: alu, sub, arith, logic, expire, sleep, clear, we, re, lin
    initial
    begin
        s = '0;
        a = '0;
        b = '0;
        ad = '0;
    end
    // One request; then all strobes but sub, arith and lin drop and the data byte is scrambled
    task automatic op(input [9:0] sv, input [7:0] av, bv, input [11:0] dv);
    begin
        @(posedge CLK);
        s <= sv;
        a <= av;
        b <= bv;
        ad <= dv;
        @(posedge CLK);
        s <= sv & 10'h181;
        a <= ~av;
    end
    endtask
endmodule // sfbl_core_model

//--- sim/sfbl_properties.sv
// Port checks of the status flag and bank layout block.
// Assumes one clock domain; bound to sfbl_top by the bench.
`timescale 1ns/10ps
module sfbl_props (
    input wire CLK,
    input wire RST_N,
    input wire POR_BOR_N,
    input wire ALU_VALID,
    input wire ALU_IS_SUB,
    input wire ALU_ARITH,
    input wire [7:0] ALU_A,
    input wire [7:0] ALU_B,
    input wire LOGIC_VALID,
    input wire [7:0] LOGIC_RESULT,
    input wire WDT_CLEAR,
    input wire SLEEP_EXEC,
    input wire WDT_EXPIRE,
    input wire DATA_LINEAR,
    input wire [11:0] DATA_ADDR,
    input wire [1:0] DATA_REGION,
    input wire PCR_SEL,
    input wire [7:0] STATUS_OUT,
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_ACK_O
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N || !POR_BOR_N);
    // Reference adder: subtract adds the two's complement
    wire [7:0] bx = ALU_IS_SUB ? ~ALU_B : ALU_B;
    wire [8:0] sum = {1'b0, ALU_A} + {1'b0, bx} + {8'h00, ALU_IS_SUB};
    wire [4:0] nib = {1'b0, ALU_A[3:0]} + {1'b0, bx[3:0]}
        + {4'h0, ALU_IS_SUB};
    // Region of a bank offset
    function automatic [1:0] rgn(input [6:0] o);
        rgn = (o >= 7'h70) ? 2'h3 : (o >= 7'h20) ? 2'h2 :
            (o >= 7'h0c) ? 2'h1 : 2'h0;
    endfunction
    property p_upper; STATUS_OUT[7:5] == 3'h0; endproperty
    a_upper: assert property (p_upper) else $error("upper bits set");
    property p_lzero; LOGIC_VALID && !ALU_VALID |=>
        STATUS_OUT[2] == ($past(LOGIC_RESULT) == 8'h00); endproperty
    a_lzero: assert property (p_lzero) else $error("zero flag");
    property p_carry; ALU_VALID && ALU_ARITH |=> STATUS_OUT[0] ==
        $past(sum[8]) && STATUS_OUT[2] == ($past(sum[7:0]) == 8'h00);
    endproperty
    a_carry: assert property (p_carry) else $error("carry");
    property p_nib; ALU_VALID && ALU_ARITH |=>
        STATUS_OUT[1] == $past(nib[4]); endproperty
    a_nib: assert property (p_nib) else $error("nibble carry");
    property p_exp; WDT_EXPIRE |=> !STATUS_OUT[4]; endproperty
    a_exp: assert property (p_exp) else $error("time-out flag");
    property p_slp; SLEEP_EXEC |=> !STATUS_OUT[3]; endproperty
    a_slp: assert property (p_slp) else $error("power-down flag");
    property p_clr; WDT_CLEAR && !WDT_EXPIRE && !SLEEP_EXEC |=>
        STATUS_OUT[4:3] == 2'h3; endproperty
    a_clr: assert property (p_clr) else $error("clear");
    property p_ack; WB_CYC_I && WB_STB_I && !WB_ACK_O |=>
        WB_ACK_O ##1 !WB_ACK_O; endproperty
    a_ack: assert property (p_ack) else $error("bus ack");
    property p_rgn; !DATA_LINEAR |=>
        DATA_REGION == rgn($past(DATA_ADDR[6:0])) &&
        PCR_SEL == (rgn($past(DATA_ADDR[6:0])) == 2'h1); endproperty
    a_rgn: assert property (p_rgn) else $error("region");
    c_sub: cover property (ALU_VALID && ALU_IS_SUB);
    c_exp: cover property (WDT_EXPIRE);
    c_ack: cover property (WB_ACK_O);
endmodule // sfbl_props

//--- sim/sfbl_tb_top.sv
// Self-checking bench of the status flag and bank layout block.
// Assumes the core model drives the core side; bench drives bus and resets.
`timescale 1ns/10ps
module sfbl_tb_top;
    logic clk = 0, rst_n = 0, por_n = 0, o_to = 0, o_pd = 0;
    logic cyc = 0, stb = 0, we = 0, pcr, ack, irq;
    logic [31:0] adr = 0, wdat = 0, q, dout;
    logic [9:0] s;
    logic [7:0] a, b, rdata, res, st;
    logic [11:0] ad;
    logic [1:0] rg;
    int miscompares = 0, tests_run = 0, cycles = 0;
    logic [23:0] tbl [8] = '{24'h00f012, 24'h0ff017, 24'h020300,
        24'h105057, 24'h110011, 24'h101020, 24'h100007, 24'h130103};
    initial
        forever #5 clk = ~clk;
    sfbl_core_model cm (.CLK(clk), .s(s), .a(a), .b(b), .ad(ad));
    sfbl_top uut (.CLK(clk), .RST_N(rst_n), .POR_BOR_N(por_n),
        .OTHER_RST_TO(o_to), .OTHER_RST_PD(o_pd), .ALU_VALID(s[9]),
        .ALU_IS_SUB(s[8]), .ALU_ARITH(s[7]), .ALU_A(a), .ALU_B(b),
        .LOGIC_VALID(s[6]), .LOGIC_RESULT(a), .WDT_EXPIRE(s[5]),
        .SLEEP_EXEC(s[4]), .WDT_CLEAR(s[3]), .DATA_WE(s[2]), .DATA_RE(s[1]),
        .DATA_LINEAR(s[0]), .DATA_ADDR(ad), .DATA_WDATA(a),
        .DATA_RDATA(rdata), .DATA_REGION(rg), .PCR_SEL(pcr),
        .ALU_RESULT(res), .STATUS_OUT(st), .WB_ADR_I(adr), .WB_DAT_I(wdat),
        .WB_DAT_O(dout), .WB_WE_I(we), .WB_SEL_I(4'hf), .WB_STB_I(stb),
        .WB_CYC_I(cyc), .WB_ACK_O(ack), .IRQ(irq));
    task automatic chk(input string n, input [31:0] e, input [31:0] g);
        if (g !== e)
        begin
            miscompares++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
        tests_run++;
    endtask
    // Classic Wishbone cycle, held until ack is sampled
    task automatic wb(input w, input [31:0] ra, rd);
    begin
        @(posedge clk);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, ra, rd};
        do @(posedge clk); while (ack !== 1'b1);
        q = dout;
        {cyc, stb} <= 2'b00;
    end
    endtask
    task automatic step(input [9:0] sv, input [7:0] av, bv, input [11:0] dv);
    begin
        cm.op(sv, av, bv, dv);
        #1;
    end
    endtask
    task automatic rst(input p, t, d);
    begin
        @(posedge clk);
        {rst_n, por_n, o_to, o_pd} <= {1'b0, p, t, d};
        repeat (5) @(posedge clk);
        {rst_n, por_n} <= 2'b11;
        @(posedge clk);
        #1;
    end
    endtask
    task automatic t_arith;
        logic [7:0] e;
        for (int i = 0; i < 8; i++)
        begin
            e = tbl[i][20] ? tbl[i][19:12] - tbl[i][11:4] :
                tbl[i][19:12] + tbl[i][11:4];
            step({1'b1, tbl[i][20], 8'h80}, tbl[i][19:12], tbl[i][11:4], 0);
            chk("flags", tbl[i][2:0], st[2:0]);
            chk("result", e, res);
        end
        step(10'h040, 8'h00, 0, 0);
        chk("zero", 1, st[2]);
        step(10'h040, 8'h05, 0, 0);
        chk("nonzero", 0, st[2]);
        $display("arith done");
    endtask
    task automatic t_cause;
        step(10'h020, 0, 0, 0);
        chk("expire", 2'h1, st[4:3]);
        step(10'h010, 0, 0, 0);
        chk("sleep", 2'h2, st[4:3]);
        step(10'h008, 0, 0, 0);
        chk("wclear", 2'h3, st[4:3]);
        step(10'h004, 8'hff, 0, 12'h003);
        chk("st write", 8'h1f, st);
        step(10'h284, 8'h07, 8'h01, 12'h183);
        chk("st alu wr", 3'h0, st[2:0]);
        step(10'h280, 8'hff, 8'h01, 0);
        rst(1, 0, 1);
        chk("other rst", 8'h0f, st);
        $display("cause done");
    endtask
    task automatic t_mem;
        step(10'h004, 8'h5a, 0, 12'h070);
        step(10'h002, 0, 0, 12'h2f0);
        chk("common", 8'h5a, rdata);
        step(10'h004, 8'h3c, 0, 12'h0a0);
        step(10'h004, 8'hc3, 0, 12'h120);
        step(10'h002, 0, 0, 12'h0a0);
        chk("general", 8'h3c, rdata);
        step(10'h003, 0, 0, 12'h050);
        chk("linear", 8'h3c, rdata);
        step(10'h003, 0, 0, 12'ha00);
        chk("unimpl", 8'h00, rdata);
        step(10'h002, 0, 0, 12'h00c);
        chk("pcr sel", 1, pcr);
        chk("region", 2'h1, rg);
        wb(0, 32'h4, 0);
        chk("access", 32'h1, q);
        $display("mem done");
    endtask
    task automatic t_irq;
        wb(1, 32'hc, 1);
        wb(1, 32'h8, 32'hf);
        chk("irq idle", 0, irq);
        step(10'h020, 0, 0, 0);
        chk("irq set", 1, irq);
        wb(0, 32'h8, 0);
        chk("int stat", 1, q[0]);
        wb(1, 32'h8, 1);
        chk("irq clr", 0, irq);
        step(10'h010, 0, 0, 0);
        chk("irq mask", 0, irq);
        wb(1, 32'h0, 32'hfa);
        wb(0, 32'h0, 0);
        chk("wb st wr", 32'h12, q);
        wb(0, 32'hc, 0);
        chk("mask", 32'h1, q);
        wb(0, 32'h20, 0);
        chk("unmapped", 0, q);
        $display("irq done");
    endtask
    task automatic summarize;
    begin
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    end
    endtask
    // Hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            miscompares++;
            summarize();
        end
    end
    initial
    begin
        rst(0, 0, 0);
        chk("por", 8'h18, st);
        wb(0, 32'h0, 0);
        chk("wb status", 8'h18, q[7:0]);
        t_arith();
        t_cause();
        t_mem();
        t_irq();
        summarize();
    end
endmodule // sfbl_tb_top
bind sfbl_top sfbl_props u_props (.CLK, .RST_N, .POR_BOR_N, .ALU_VALID,
    .ALU_IS_SUB, .ALU_ARITH, .ALU_A, .ALU_B, .LOGIC_VALID, .LOGIC_RESULT,
    .WDT_CLEAR, .SLEEP_EXEC, .WDT_EXPIRE, .DATA_LINEAR, .DATA_ADDR,
    .DATA_REGION, .PCR_SEL, .STATUS_OUT, .WB_CYC_I, .WB_STB_I, .WB_ACK_O);
